/* verilog/clock_control.sv */
// Clock source selection, prescaler and power modes of the MCU core.
// Assumes oscillators and the counter pin arrive unsynchronised; wake
// and config inputs come from logic on aclk. Clock outputs are tick enables; the rest are levels.
`timescale 1ns/1ps
module clock_control
#(
   parameter int N_PERIPH = 4
)
(
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire clk_ctrl_pkg::axi_req_t bus_req,
   output      clk_ctrl_pkg::axi_rsp_t bus_rsp,
   input  wire clk_ctrl_pkg::cfg_bits_t cfg,
   input  wire logic                   crystal_osc,
   input  wire logic                   fast_rc_osc,
   input  wire logic                   slow_rc_osc,
   input  wire logic                   counter_zero_pin,
   input  wire logic                   irq_wake,
   input  wire logic                   ext_irq_zero,
   input  wire logic                   ext_irq_one,
   output      logic                   cpu_tick,
   output      logic                   cpu_cycle_tick,
   output      logic                   periph_tick,
   output      logic [N_PERIPH-1:0]    periph_cycle_tick,
   output      logic                   watchdog_tick,
   output      logic                   timer_zero_tick,
   output      logic                   crystal_run,
   output      logic                   fast_rc_run,
   output      logic                   slow_rc_run,
   output      logic                   crystal_gain,
   output      logic                   osc_pins_gpio,
   output      logic                   no_clock
);
   import clk_ctrl_pkg::*;

   // Peripheral bits share one byte with the double speed bit
   if (N_PERIPH < 1 || N_PERIPH > 7)
   begin : g_bad_periph
      $error("N_PERIPH must be 1 to 7");
   end

   function automatic logic [8:0] div_last(input logic [7:0] r);
      div_last = DIV_TOP - {r, 1'b0};
   endfunction

   function automatic logic src_tick(input src_t s,
                                     input logic [3:0] t);
      case (s)
         SRC_XTAL: src_tick = t[PIN_XTAL];
         SRC_FRC:  src_tick = t[PIN_FRC];
         SRC_SLOW: src_tick = t[PIN_SLOW];
         default:  src_tick = 1'b0;
      endcase
   endfunction

   // Pin synchronisers: a change counts when stages two and three agree
   logic [3:0] s1_q, s2_q, s3_q, lvl_q, rise_q, lvl_d;
   assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q   <= 4'h0;
         s2_q   <= 4'h0;
         s3_q   <= 4'h0;
         lvl_q  <= 4'h0;
         rise_q <= 4'h0;
      end
      else
      begin
         s1_q   <= {counter_zero_pin, slow_rc_osc, fast_rc_osc, crystal_osc};
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         lvl_q  <= lvl_d;
         rise_q <= lvl_d & ~lvl_q;
      end
   end

   // Configuration caught while reset is held
   cfg_bits_t cfg_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_q <= cfg;
   end

   // Software visible control
   logic                cks_q, xtal_en_q, frc_en_q, t0sub_q;
   logic                idle_q, pd_q, x2_q;
   logic [N_PERIPH-1:0] px2_q;
   logic [7:0]          div_q;
   logic                wr_go, wr_ok;
   logic [7:0]          wr_idx;
   logic [7:0]          wr_byte;
   logic                wake_any, wake_pd, set_idle, set_pd;

   assign wake_pd  = ext_irq_zero | ext_irq_one;
   assign wake_any = wake_pd | irq_wake;
   assign set_idle = wr_go && wr_ok && wr_idx == IDX_PWR_CTRL
                     && wr_byte[PWR_IDLE_BIT];
   assign set_pd   = wr_go && wr_ok && wr_idx == IDX_PWR_CTRL
                     && wr_byte[PWR_PD_BIT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cks_q     <= cfg.rst_osc_choice;
         xtal_en_q <= cfg.rst_osc_choice;
         frc_en_q  <= ~cfg.rst_osc_choice;
         t0sub_q   <= 1'b0;
         x2_q      <= 1'b0;
         px2_q     <= '0;
         div_q     <= DIV_RST;
      end
      else if (wr_go && wr_ok)
      begin
         case (wr_idx)
            IDX_SRC_SEL:  cks_q <= wr_byte[0];
            IDX_OSC_CTRL:
            begin
               xtal_en_q <= wr_byte[OSC_XTAL_EN_BIT];
               frc_en_q  <= wr_byte[OSC_FRC_EN_BIT];
               t0sub_q   <= wr_byte[OSC_T0SUB_BIT];
            end
            IDX_CFG_A:
            begin
               x2_q  <= wr_byte[CFGA_X2_BIT];
               px2_q <= wr_byte[CFGA_PX2_LSB +: N_PERIPH];
            end
            IDX_DIV:      div_q <= wr_byte;
            default:      ;
         endcase
      end
   end

   // Request bits; a write setting a bit beats a wake in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         idle_q <= 1'b0;
         pd_q   <= 1'b0;
      end
      else
      begin
         if (set_idle)
            idle_q <= 1'b1;
         else if (wake_any)
            idle_q <= 1'b0;
         if (set_pd)
            pd_q <= 1'b1;
         else if (wake_pd)
            pd_q <= 1'b0;
      end
   end

   // Source choice
   logic slow_on, sel_en;
   src_t target;
   assign slow_on = ~(cfg_q.slow_rc_disable | cfg_q.watchdog_rc_off);
   assign sel_en  = cks_q ? xtal_en_q : frc_en_q;
   always_comb
   begin
      if (pd_q)
         target = SRC_NONE;
      else if (sel_en)
         target = cks_q ? SRC_XTAL : SRC_FRC;
      else if (slow_on)
         target = SRC_SLOW;
      else
         target = SRC_NONE;
   end

   // Changes to a running source wait for its edge, so no runt tick escapes; a change to none is immediate
   sw_state_t sw_q;
   src_t      active_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sw_q     <= SW_WAIT;
         active_q <= SRC_NONE;
      end
      else
      begin
         case (sw_q)
            SW_RUN:
               if (target != active_q)
                  sw_q <= SW_WAIT;
            SW_WAIT:
               if (target == SRC_NONE || src_tick(target, rise_q))
               begin
                  active_q <= target;
                  sw_q     <= SW_RUN;
               end
            default:
               sw_q <= SW_WAIT;
         endcase
      end
   end

   // Prescaler
   logic       raw_tick, int_tick;
   logic [8:0] div_cnt_q;
   assign raw_tick = sw_q == SW_RUN && target == active_q
                     && src_tick(active_q, rise_q);
   assign int_tick = raw_tick
                     && (x2_q || div_cnt_q >= div_last(div_q));
   always_ff @(posedge aclk)
   begin
      // New reload restarts the count, so a shorter ratio never overshoots
      if (!aresetn || sw_q != SW_RUN
          || (wr_go && wr_ok && wr_idx == IDX_DIV))
         div_cnt_q <= 9'h000;
      else if (int_tick)
         div_cnt_q <= 9'h000;
      else if (raw_tick)
         div_cnt_q <= div_cnt_q + 9'h001;
   end

   // CPU and peripheral machine cycles
   logic                cpu_en;
   logic [3:0]          cpu_cnt_q;
   logic [3:0]          pcnt_q [N_PERIPH];
   assign cpu_en = int_tick && !idle_q && !pd_q;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cpu_cnt_q      <= 4'h0;
         cpu_tick       <= 1'b0;
         cpu_cycle_tick <= 1'b0;
      end
      else
      begin
         cpu_tick       <= cpu_en;
         cpu_cycle_tick <= 1'b0;
         if (cpu_en)
         begin
            if (cpu_cnt_q >= (x2_q ? CYC_X2 : CYC_STD))
            begin
               cpu_cnt_q      <= 4'h0;
               cpu_cycle_tick <= 1'b1;
            end
            else
               cpu_cnt_q <= cpu_cnt_q + 4'h1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         periph_tick       <= 1'b0;
         periph_cycle_tick <= '0;
         for (int i = 0; i < N_PERIPH; i++)
            pcnt_q[i] <= 4'h0;
      end
      else
      begin
         periph_tick       <= int_tick && !pd_q;
         periph_cycle_tick <= '0;
         for (int i = 0; i < N_PERIPH; i++)
         begin
            if (int_tick && !pd_q)
            begin
               if (pcnt_q[i] >= ((x2_q && px2_q[i]) ? CYC_X2 : CYC_STD))
               begin
                  pcnt_q[i]            <= 4'h0;
                  periph_cycle_tick[i] <= 1'b1;
               end
               else
                  pcnt_q[i] <= pcnt_q[i] + 4'h1;
            end
         end
      end
   end

   // Oscillator controls and side clocks
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         watchdog_tick   <= 1'b0;
         timer_zero_tick <= 1'b0;
         crystal_run     <= 1'b0;
         fast_rc_run     <= 1'b0;
         slow_rc_run     <= 1'b0;
         crystal_gain    <= 1'b0;
         osc_pins_gpio   <= 1'b1;
         no_clock        <= 1'b0;
      end
      else
      begin
         if (slow_on)
            watchdog_tick <= rise_q[PIN_SLOW];
         else
            watchdog_tick <= cfg_q.watchdog_rc_off && raw_tick;
         if (t0sub_q)
            timer_zero_tick <= rise_q[PIN_XTAL] && crystal_run;
         else
            timer_zero_tick <= rise_q[PIN_T0];
         crystal_run   <= xtal_en_q && !pd_q;
         fast_rc_run   <= frc_en_q && !pd_q;
         slow_rc_run   <= slow_on;
         crystal_gain  <= cfg_q.crystal_gain_select;
         osc_pins_gpio <= !(cks_q && xtal_en_q);
         no_clock      <= !pd_q && !sel_en && !slow_on;
      end
   end

   // AXI4-Lite slave, one write and one read at a time
   logic          aw_have_q, w_have_q, aw_take, w_take;
   logic          aw_have_n, w_have_n, bvalid_n, ar_take, rvalid_n;
   logic [AW-1:0] aw_addr_q;
   logic [31:0]   wdata_q;
   logic          wstrb0_q;
   logic [31:0]   rd_d;
   logic          rd_ok;
   assign aw_take   = bus_req.awvalid && bus_rsp.awready;
   assign w_take    = bus_req.wvalid && bus_rsp.wready;
   assign wr_go     = aw_have_q && w_have_q && !bus_rsp.bvalid;
   assign aw_have_n = (aw_have_q || aw_take) && !wr_go;
   assign w_have_n  = (w_have_q || w_take) && !wr_go;
   assign bvalid_n  = wr_go || (bus_rsp.bvalid && !bus_req.bready);
   assign ar_take   = bus_req.arvalid && bus_rsp.arready;
   assign rvalid_n  = ar_take || (bus_rsp.rvalid && !bus_req.rready);
   assign wr_idx    = aw_addr_q[9:2];
   assign wr_byte   = wstrb0_q ? wdata_q[7:0] : 8'h00;
   // Only writable registers in the map take a write
   assign wr_ok     = aw_addr_q[AW-1:10] == '0 && wr_idx inside
                      {IDX_SRC_SEL, IDX_OSC_CTRL, IDX_PWR_CTRL,
                       IDX_CFG_A, IDX_DIV};

   always_comb
   begin
      rd_d  = 32'h0000_0000;
      rd_ok = bus_req.araddr[AW-1:10] == '0;
      case (bus_req.araddr[9:2])
         IDX_SRC_SEL:  rd_d[0] = cks_q;
         IDX_OSC_CTRL: rd_d[2:0] = {t0sub_q, frc_en_q, xtal_en_q};
         IDX_PWR_CTRL: rd_d[1:0] = {pd_q, idle_q};
         IDX_STATUS:   rd_d[4:0] = {no_clock, sw_q == SW_WAIT,
                                    active_q == SRC_SLOW, active_q};
         IDX_CFG_A:    rd_d[N_PERIPH:0] = {px2_q, x2_q};
         IDX_DIV:      rd_d[7:0] = div_q;
         IDX_CFG_BYTE:
         begin
            rd_d[CFGB_WD_OFF_BIT] = cfg_q.watchdog_rc_off;
            rd_d[CFGB_GAIN_BIT]   = cfg_q.crystal_gain_select;
            rd_d[CFGB_RST_OSC]    = cfg_q.rst_osc_choice;
            rd_d[CFGB_SLOW_DIS]   = cfg_q.slow_rc_disable;
         end
         default:      rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bus_rsp   <= '0;
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= '0;
         wdata_q   <= 32'h0000_0000;
         wstrb0_q  <= 1'b0;
      end
      else
      begin
         aw_have_q       <= aw_have_n;
         w_have_q        <= w_have_n;
         bus_rsp.awready <= !aw_have_n && !bvalid_n;
         bus_rsp.wready  <= !w_have_n && !bvalid_n;
         bus_rsp.bvalid  <= bvalid_n;
         bus_rsp.arready <= !rvalid_n;
         bus_rsp.rvalid  <= rvalid_n;
         if (aw_take)
            aw_addr_q <= bus_req.awaddr;
         if (w_take)
         begin
            wdata_q  <= bus_req.wdata;
            wstrb0_q <= bus_req.wstrb[0];
         end
         if (wr_go)
            bus_rsp.bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         if (ar_take)
         begin
            bus_rsp.rdata <= rd_ok ? rd_d : 32'h0000_0000;
            bus_rsp.rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_reset_values: assert property (
      !$past(aresetn) |-> div_q == DIV_RST && !x2_q && !idle_q && !pd_q)
      else $error("reset values of divider or mode bits wrong");
   a_div_factor: assert property (
      int_tick && !x2_q |-> div_cnt_q == DIV_TOP - {div_q, 1'b0})
      else $error("prescaler ratio does not match reload");
   a_x2_bypass: assert property (
      x2_q && raw_tick && !pd_q |=> periph_tick)
      else $error("double speed did not bypass prescaler");
   a_idle_cpu_stop: assert property (
      idle_q ##1 idle_q |-> !cpu_tick && !cpu_cycle_tick)
      else $error("cpu ticked during idle");
   a_pd_osc_stop: assert property (
      pd_q |=> !crystal_run && !fast_rc_run && !periph_tick)
      else $error("clocks running in power down");
   a_rescue_src: assert property (
      raw_tick && active_q == SRC_SLOW |-> slow_on && !sel_en)
      else $error("rescue clock used without cause");
   a_switch_quiet: assert property (
      sw_q == SW_WAIT |-> !int_tick ##1 !periph_tick)
      else $error("tick during source switch");
   a_idle_wake: assert property (
      idle_q && irq_wake && !set_idle && !(wr_go && wr_ok)
      |=> !idle_q && $stable(cks_q) && $stable(xtal_en_q)
          && $stable(frc_en_q))
      else $error("idle exit wrong");
   a_t0_pin: assert property (
      !t0sub_q && rise_q[PIN_T0] |=> timer_zero_tick)
      else $error("timer zero pin edge lost");

   c_switch_src: cover property (sw_q == SW_WAIT ##[1:50] sw_q == SW_RUN);
   c_rescue: cover property (active_q == SRC_SLOW && raw_tick);
   c_pd_wake: cover property (pd_q ##1 wake_pd ##1 !pd_q);
endmodule

/* shared/clk_ctrl_pkg.sv */
// Constants, register map and carriers of the clock control block.
// Assumes an AXI4-Lite master with 12-bit byte addresses, 32-bit data.
package clk_ctrl_pkg;
   localparam int AW = 12;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_SRC_SEL  = 8'h85;
   localparam logic [7:0] IDX_OSC_CTRL = 8'h86;
   localparam logic [7:0] IDX_PWR_CTRL = 8'h87;
   localparam logic [7:0] IDX_STATUS   = 8'h88;
   localparam logic [7:0] IDX_CFG_A    = 8'h8f;
   localparam logic [7:0] IDX_DIV      = 8'h97;
   localparam logic [7:0] IDX_CFG_BYTE = 8'hef;
   localparam int OSC_XTAL_EN_BIT = 0;
   localparam int OSC_FRC_EN_BIT  = 1;
   localparam int OSC_T0SUB_BIT   = 2;
   localparam int PWR_IDLE_BIT    = 0;
   localparam int PWR_PD_BIT      = 1;
   localparam int CFGA_X2_BIT     = 0;
   localparam int CFGA_PX2_LSB    = 1;
   localparam int CFGB_WD_OFF_BIT = 1;
   localparam int CFGB_GAIN_BIT   = 3;
   localparam int CFGB_RST_OSC    = 4;
   localparam int CFGB_SLOW_DIS   = 5;
   localparam logic [7:0] DIV_RST = 8'hff;
   localparam logic [8:0] DIV_TOP = 9'h1ff;
   localparam logic [3:0] CYC_STD = 4'hb;
   localparam logic [3:0] CYC_X2  = 4'h5;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Synchronised pin indices
   localparam int PIN_XTAL = 0;
   localparam int PIN_FRC  = 1;
   localparam int PIN_SLOW = 2;
   localparam int PIN_T0   = 3;

   typedef enum logic [1:0] {
      SRC_NONE = 2'b00,
      SRC_XTAL = 2'b01,
      SRC_FRC  = 2'b10,
      SRC_SLOW = 2'b11
   } src_t;

   typedef enum logic [1:0] {
      SW_RUN  = 2'b00,
      SW_WAIT = 2'b01
   } sw_state_t;

   typedef struct packed {
      logic          rst_osc_choice;
      logic          crystal_gain_select;
      logic          watchdog_rc_off;
      logic          slow_rc_disable;
   } cfg_bits_t;

   typedef struct packed {
      logic [AW-1:0] awaddr;
      logic          awvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          wvalid;
      logic          bready;
      logic [AW-1:0] araddr;
      logic          arvalid;
      logic          rready;
   } axi_req_t;

   typedef struct packed {
      logic          awready;
      logic          wready;
      logic [1:0]    bresp;
      logic          bvalid;
      logic          arready;
      logic [31:0]   rdata;
      logic [1:0]    rresp;
      logic          rvalid;
   } axi_rsp_t;
endpackage

/* testbench/tick_consumer.sv */
// Consumer side of the clock outputs: counts ticks, measures gaps.
// Assumes one-cycle tick pulses on aclk.
`timescale 1ns/1ps
module tick_consumer
(
   input  wire logic       aclk,
   input  wire logic [5:0] ticks,
   output      int         gap [6],
   output      int         cnt [6]
);
   int age [6];

   // Gap in aclk cycles since the previous tick on the same line
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < 6; i++)
      begin
         age[i] <= ticks[i] ? 1 : age[i] + 1;
         if (ticks[i])
         begin
            gap[i] <= age[i];
            cnt[i] <= cnt[i] + 1;
         end
      end
   end
endmodule

/* testbench/clock_control_tb.sv */
// Self-checking bench of clock_control.
// Assumes tick_consumer measures tick gaps; oscillators are made here.
`timescale 1ns/1ps
module clock_control_tb;
   import clk_ctrl_pkg::*;
   logic       aclk = 1'b0;
   logic       aresetn = 1'b0;
   axi_req_t   req = '0;
   axi_rsp_t   rsp;
   cfg_bits_t  cfg = 4'b1100;
   logic       crystal_osc = 1'b0, fast_rc_osc = 1'b0;
   logic       slow_rc_osc = 1'b0, counter_zero_pin = 1'b0;
   logic       irq_wake = 1'b0, ext_irq_zero = 1'b0, ext_irq_one = 1'b0;
   logic       cpu_tick, cpu_cycle_tick, periph_tick, watchdog_tick;
   logic       timer_zero_tick, crystal_run, fast_rc_run, slow_rc_run;
   logic       crystal_gain, osc_pins_gpio, no_clock;
   logic [3:0] periph_cycle_tick;
   int         gap [6];
   int         cnt [6];
   int         ph = 0;
   int         bad_count = 0;
   int         comparisons = 0;

   always #12.5 aclk = ~aclk;

   // Oscillator levels held 3 to 6 cycles, above the 2-cycle synchroniser minimum
   always @(posedge aclk)
   begin
      ph <= ph + 1;
      crystal_osc <= (ph % 8) < 4;
      fast_rc_osc <= (ph % 6) < 3;
      slow_rc_osc <= (ph % 10) < 5;
      counter_zero_pin <= (ph % 12) < 6;
   end

   clock_control DUT (.aclk, .aresetn, .bus_req(req), .bus_rsp(rsp), .cfg,
      .crystal_osc, .fast_rc_osc, .slow_rc_osc, .counter_zero_pin,
      .irq_wake, .ext_irq_zero, .ext_irq_one, .cpu_tick, .cpu_cycle_tick,
      .periph_tick, .periph_cycle_tick, .watchdog_tick, .timer_zero_tick,
      .crystal_run, .fast_rc_run, .slow_rc_run, .crystal_gain,
      .osc_pins_gpio, .no_clock);

   tick_consumer partner (.aclk, .gap, .cnt, .ticks({timer_zero_tick,
      watchdog_tick, periph_cycle_tick[0], cpu_cycle_tick, cpu_tick,
      periph_tick}));

   task automatic wrap_up();
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
      end
   endtask

   task automatic limit(input int n);
      if (n >= 20000)
      begin
         bad_count++;
         $display("BAD %0t wait ran out", $time);
         wrap_up();
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] er = RESP_OKAY);
      int n;
      @(posedge aclk);
      req.awaddr <= {2'b00, idx, 2'b00};
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (req.awvalid && rsp.awready === 1'b1)
            req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready === 1'b1)
            req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1 && n < 20000);
      limit(n);
      req.bready <= 1'b0;
      chk(rsp.bresp, er, "bresp");
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                     input logic [1:0] er = RESP_OKAY);
      int n;
      @(posedge aclk);
      req.araddr <= {2'b00, idx, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (req.arvalid && rsp.arready === 1'b1)
            req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1 && n < 20000);
      limit(n);
      req.rready <= 1'b0;
      chk(rsp.rdata, {24'h0, exp}, "rdata");
      chk(rsp.rresp, er, "rresp");
   endtask

   task automatic wait_ticks(input int i, input int n);
      int c0;
      int k;
      c0 = cnt[i];
      k = 0;
      while (cnt[i] - c0 < n && k < 20000)
      begin
         @(posedge aclk);
         k++;
      end
      limit(k);
   endtask

   // Third gap, so a gap straddling a setting change is never judged
   task automatic gapchk(input int i, input int exp);
      wait_ticks(i, 3);
      chk(gap[i], exp, "tick gap");
   endtask

   task automatic quiet(input int i, input int cycles);
      int c0;
      repeat (2) @(posedge aclk);
      c0 = cnt[i];
      repeat (cycles) @(posedge aclk);
      chk(cnt[i] - c0, 0, "ticks while stopped");
   endtask

   task automatic wake(input logic [2:0] w);
      @(posedge aclk);
      {irq_wake, ext_irq_zero, ext_irq_one} <= w;
      @(posedge aclk);
      {irq_wake, ext_irq_zero, ext_irq_one} <= 3'b000;
   endtask

   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask

   task automatic reset_values();
      rd(IDX_DIV, DIV_RST);
      rd(IDX_CFG_A, 8'h00);
      rd(IDX_PWR_CTRL, 8'h00);
      rd(IDX_OSC_CTRL, 8'h01);
      rd(IDX_SRC_SEL, 8'h01);
      rd(IDX_CFG_BYTE, 8'h18);
      chk(crystal_gain, 1'b1, "gain");
   endtask

   task automatic bus_errors();
      rd(8'h90, 8'h00, RESP_SLVERR);
      wr(8'h90, 8'h55, RESP_SLVERR);
      wr(IDX_STATUS, 8'h01, RESP_SLVERR);
      wr(IDX_CFG_BYTE, 8'h00, RESP_SLVERR);
      rd(IDX_CFG_BYTE, 8'h18);
   endtask

   task automatic prescaler();
      logic [7:0] dv [4] = '{8'hfe, 8'hfc, 8'h00, 8'hff};
      foreach (dv[i])
      begin
         wr(IDX_DIV, dv[i]);
         rd(IDX_DIV, dv[i]);
         gapchk(0, 16 * (256 - dv[i]));
      end
   endtask

   task automatic double_speed();
      wr(IDX_CFG_A, 8'h03);
      gapchk(1, 8);
      gapchk(2, 48);
      gapchk(3, 48);
      wr(IDX_CFG_A, 8'h01);
      gapchk(3, 96);
      wr(IDX_CFG_A, 8'h00);
      gapchk(2, 192);
   endtask

   task automatic switching();
      wr(IDX_OSC_CTRL, 8'h03);
      wr(IDX_SRC_SEL, 8'h00);
      gapchk(0, 12);
      rd(IDX_STATUS, 8'h02);
      chk(osc_pins_gpio, 1'b1, "pins free");
      wr(IDX_OSC_CTRL, 8'h01);
      gapchk(0, 20);
      rd(IDX_STATUS, 8'h07);
      wr(IDX_SRC_SEL, 8'h01);
      gapchk(0, 16);
      chk(osc_pins_gpio, 1'b0, "pins owned");
      gapchk(4, 10);
   endtask

   task automatic timer_zero();
      wr(IDX_OSC_CTRL, 8'h05);
      gapchk(5, 8);
      wr(IDX_OSC_CTRL, 8'h01);
      gapchk(5, 12);
   endtask

   task automatic idle_mode();
      wr(IDX_OSC_CTRL, 8'h01);
      wr(IDX_PWR_CTRL, 8'h01);
      quiet(1, 100);
      gapchk(0, 16);
      wake(3'b100);
      rd(IDX_PWR_CTRL, 8'h00);
      rd(IDX_OSC_CTRL, 8'h01);
      wait_ticks(1, 2);
   endtask

   task automatic power_down();
      wr(IDX_PWR_CTRL, 8'h02);
      quiet(0, 100);
      chk({crystal_run, fast_rc_run, slow_rc_run}, 3'b001, "run");
      gapchk(4, 10);
      wake(3'b010);
      wait_ticks(0, 2);
      chk(crystal_run, 1'b1, "crystal back");
      rd(IDX_SRC_SEL, 8'h01);
   endtask

   task automatic reset_from_pd();
      wr(IDX_PWR_CTRL, 8'h02);
      cfg <= 4'b0001;
      do_reset();
      chk({crystal_run, fast_rc_run, slow_rc_run, osc_pins_gpio},
          4'b0101, "run after reset");
      rd(IDX_SRC_SEL, 8'h00);
      rd(IDX_PWR_CTRL, 8'h00);
      gapchk(0, 12);
      wr(IDX_PWR_CTRL, 8'h02);
      quiet(0, 100);
      chk(slow_rc_run, 1'b0, "total stop");
      wake(3'b001);
      wait_ticks(0, 2);
      wr(IDX_OSC_CTRL, 8'h00);
      repeat (20) @(posedge aclk);
      chk(no_clock, 1'b1, "no clock");
      cfg <= 4'b0010;
      do_reset();
      rd(IDX_CFG_BYTE, 8'h02);
      chk({slow_rc_run, crystal_gain}, 2'b00, "slow off");
      gapchk(4, 6);
   endtask

   initial
   begin
      do_reset();
      reset_values();
      bus_errors();
      prescaler();
      double_speed();
      switching();
      timer_zero();
      idle_mode();
      power_down();
      reset_from_pd();
      wrap_up();
   end
endmodule
